/* dv/scp_host.sv */
// Host processor model that drives the command port pins.
// Assumes core_clk at 50 MHz and a port that syncs every pin it sees.
`timescale 1ns/1ns

module scp_host (
   input  wire logic        core_clk,
   output logic             cs_n,
   output logic             rd_n,
   output logic             wr_n,
   output logic             ale,
   output logic      [1:0]  addr_pin,
   output logic      [7:0]  db_in,
   input  wire logic [7:0]  db_out,
   input  wire logic        db_oe,
   input  wire logic        rdy_int
);
   logic        use_ale = 1'b0;
   logic        drv     = 1'b0;
   logic  [7:0] drv_val = 8'h00;
   logic  [7:0] last_val = 8'h00;
   int          stalls   = 0;

   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      ale = 1'b0;
      addr_pin = 2'h0;
   end

   // Nothing pulls the bus, so a released bus shows the inverse level.
   always_comb begin
      if (db_oe)
         db_in = db_out;
      else if (drv)
         db_in = drv_val;
      else
         db_in = ~last_val;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cycles

   task automatic addr_phase(input logic [1:0] a);
      if (use_ale) begin
         drv_val = {6'h00, a};
         drv = 1'b1;
         ale = 1'b1;
         cycles(3);
         ale = 1'b0;
         cycles(1);
      end else begin
         addr_pin = a;
      end
   endtask : addr_phase

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      addr_phase(a);
      drv_val = d;
      drv = 1'b1;
      cs_n = 1'b0;
      wr_n = 1'b0;
      cycles(3);
      cs_n = 1'b1;
      wr_n = 1'b1;
      cycles(1);
      last_val = d;
      drv = 1'b0;
      cycles(2);
   endtask : wr

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      addr_phase(a);
      last_val = drv_val;
      drv = 1'b0;
      cs_n = 1'b0;
      rd_n = 1'b0;
      cycles(5);
      d = db_out;
      cs_n = 1'b1;
      rd_n = cs_n;
      cycles(5);
   endtask : rd

   // A new command goes out once the last one has finished, or after at most 40 cycles of waiting for ready.
   task automatic cmd(input logic [7:0] c, output logic busy_low);
      int n;
      wr(2'h0, c);
      cycles(2);
      busy_low = ~rdy_int;
      n = 0;
      while (rdy_int !== 1'b1 && n < 40) begin
         cycles(1);
         n++;
      end
      // A missing ready level or completion pulse counts against the run.
      if (rdy_int !== 1'b1)
         stalls++;
      cycles(1);
   endtask : cmd
endmodule : scp_host

/* dv/test_synth_command_register_port.sv */
// Self-checking bench for the command port through its host pins.
// Assumes the host model beside it and a 50 MHz core clock.
`timescale 1ns/1ns

module test_synth_command_register_port;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sample_tick = 1'b0;
   logic        cs_n, rd_n, wr_n, ale, db_oe, rdy_int, bl;
   logic  [1:0] addr_pin;
   logic  [7:0] db_in, db_out, aux_cmd;
   logic        ale_mode, int_mode, individual_mode, harm40_mode;
   logic        sequencer_run_bit, noise_init_bit, samp_hold_zero;
   logic        aux_cmd_stb, aux_is_noise;
   int          num_errors = 0;
   int          checked = 0;
   int          aux_seen = 0;
   logic  [7:0] opt_tab [4] = '{8'h24, 8'h28, 8'h22, 8'h23};

   always #10 core_clk = ~core_clk;

   always @(posedge core_clk)
      if (aux_cmd_stb === 1'b1)
         aux_seen++;

   scp_host host (.core_clk(core_clk), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .ale(ale), .addr_pin(addr_pin), .db_in(db_in),
      .db_out(db_out), .db_oe(db_oe), .rdy_int(rdy_int));

   scp_cmd_port dut (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .addr_pin(addr_pin),
      .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .rdy_int(rdy_int),
      .sample_tick(sample_tick), .ale_mode(ale_mode),
      .int_mode(int_mode), .individual_mode(individual_mode),
      .harm40_mode(harm40_mode), .sequencer_run_bit(sequencer_run_bit),
      .noise_init_bit(noise_init_bit), .samp_hold_zero(samp_hold_zero),
      .aux_cmd_stb(aux_cmd_stb), .aux_cmd(aux_cmd),
      .aux_is_noise(aux_is_noise));

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      num_errors += host.stalls;
      $display("mismatches %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic rd_chk(input string what, input logic [1:0] a,
                         input logic [7:0] exp);
      logic [7:0] v;
      host.rd(a, v);
      chk(what, exp, v);
   endtask : rd_chk

   task automatic modes_chk(input logic [7:0] exp);
      chk("modes", exp, {aux_is_noise, samp_hold_zero, noise_init_bit,
          sequencer_run_bit, harm40_mode, individual_mode, int_mode,
          ale_mode});
   endtask : modes_chk

   // Sample ticks are spaced two clocks apart, like a slow datapath.
   task automatic ticks(input int n);
      repeat (n) begin
         sample_tick = !sample_tick;
         host.cycles(1);
         sample_tick = !sample_tick;
         host.cycles(1);
      end
   endtask : ticks

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #1_000_000;
      num_errors++;
      close_out();
   end

   initial begin
      host.cycles(16);
      rst_n = 1'b1;
      host.cycles(2);
      modes_chk(8'h40);
      chk("idle pins", 8'h01, {6'h00, db_oe, rdy_int});
      for (int i = 1; i < 4; i++)
         host.wr(i[1:0], 8'h5A ^ i[7:0]);
      for (int i = 1; i < 4; i++)
         rd_chk("buffer", i[1:0], 8'h5A ^ i[7:0]);
      // Pitch of voice 5 loaded immediate, then read back.
      host.wr(2'h1, 8'h00);
      host.wr(2'h2, 8'h1A);
      host.wr(2'h3, 8'hBC);
      host.cmd(8'h0D, bl);
      chk("busy level", 8'h01, {7'h00, bl});
      host.wr(2'h2, 8'hFF);
      host.wr(2'h3, 8'hFF);
      host.cmd(8'h1D, bl);
      rd_chk("pitch high", 2'h2, 8'h1A);
      rd_chk("pitch low", 2'h3, 8'hBC);
      host.cmd(8'h18, bl);
      rd_chk("voice 0 low", 2'h3, 8'h00);
      // Harmonic 63 loaded immediate; buffer B must not matter.
      host.wr(2'h2, 8'h55);
      host.wr(2'h3, 8'hA7);
      host.cmd(8'h7F, bl);
      host.wr(2'h3, 8'h00);
      host.cmd(8'hFF, bl);
      rd_chk("harmonic 63", 2'h3, 8'hA7);
      // Ramp harmonic 2 by one fraction step (1/32 code) every 2 samples from 10 towards 12.
      host.wr(2'h3, 8'h10);
      host.cmd(8'h42, bl);
      host.cmd(8'h31, bl);
      modes_chk(8'h10);
      host.wr(2'h1, 8'h61);
      host.wr(2'h3, 8'h12);
      host.cmd(8'h42, bl);
      ticks(64);
      host.cmd(8'hC2, bl);
      rd_chk("ramp midway", 2'h3, 8'h11);
      ticks(200);
      host.cmd(8'hC2, bl);
      rd_chk("ramp end", 2'h3, 8'h12);
      // Halt with noise init; bits 3-2 of the byte are ignored.
      host.cmd(8'h3E, bl);
      modes_chk(8'hE0);
      host.cmd(8'h85, bl);
      chk("aux byte", 8'h85, aux_cmd);
      chk("aux strobes", 8'h01, aux_seen[7:0]);
      for (int i = 0; i < 4; i++) begin
         host.cmd(opt_tab[i], bl);
         host.use_ale = opt_tab[i][0];
         modes_chk(8'hE0 | {4'h0, opt_tab[i][3:0]});
      end
      // Address now comes from the bus; the pins stay at zero.
      host.wr(2'h3, 8'h3C);
      rd_chk("latched address", 2'h3, 8'h3C);
      host.cmd(8'h20, bl);
      host.use_ale = 1'b0;
      modes_chk(8'hE0);
      rd_chk("pin address", 2'h3, 8'h3C);
      host.cmd(8'h31, bl);
      rst_n = 1'b0;
      host.cycles(4);
      rst_n = 1'b1;
      host.cycles(2);
      modes_chk(8'h40);
      close_out();
   end
endmodule : test_synth_command_register_port

/* hw/scp_cmd_port.sv */
// Command interpreter of the synthesizer host port with its voice and
// harmonic breakpoint storage and envelope stepping.
// Assumes a host bus on asynchronous pins and a sample tick from the
// datapath on core_clk.
`timescale 1ns/1ns
`include "scp_map.svh"

module scp_cmd_port #(
   parameter int unsigned EXEC_CYCLES = `SCP_EXEC_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic        ale,
   input  wire logic [1:0]  addr_pin,
   input  wire logic [7:0]  db_in,
   output logic      [7:0]  db_out,
   output logic             db_oe,
   output logic             rdy_int,
   input  wire logic        sample_tick,
   output logic             ale_mode,
   output logic             int_mode,
   output logic             individual_mode,
   output logic             harm40_mode,
   output logic             sequencer_run_bit,
   output logic             noise_init_bit,
   output logic             samp_hold_zero,
   output logic             aux_cmd_stb,
   output logic      [7:0]  aux_cmd,
   output logic             aux_is_noise
);

   ////////////////////////////////////////////////////////////////////////////

   localparam int EXEC_MAX = EXEC_CYCLES + 1;

   logic [13:0] sync_q;
   logic        cs_s;
   logic        rd_s;
   logic        wr_s;
   logic        ale_s;
   logic [1:0]  addr_s;
   logic [7:0]  data_s;
   logic [1:0]  sel_addr;
   logic        wr_trail;
   logic        done;
   logic [6:0]  harm_lim;

   scp_pkg::scp_regs_t r_q;
   scp_pkg::scp_regs_t r_d;

   scp_sync #(
      .W       (14),
      .RST_VAL (`SCP_SYNC_RST)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   ({cs_n, rd_n, wr_n, ale, addr_pin, db_in}),
      .pin_out  (sync_q)
   );

   assign {cs_s, rd_s, wr_s, ale_s, addr_s, data_s} = sync_q;

   ////////////////////////////////////////////////////////////////////////////

   // The increment is the sign bit joined to the mantissa as one signed
   // six-bit number; the current value carries extra fraction bits so that
   // single steps are finer than a destination code.
   function automatic logic [17:0] step_env(input logic [17:0] cur,
                                            input logic [7:0]  slope,
                                            input logic [17:0] tgt);
      logic [18:0] inc;
      logic [18:0] sum;
      logic        neg;
      neg = slope[`SCP_SLOPE_SIGN];
      inc = {{13{neg}}, neg, slope[`SCP_MANT_HI:0]};         // [R3] [R8]
      sum = {1'b0, cur} + inc;
      // A zero mantissa with the sign bit clear holds the envelope where it stands.
      if (cur == tgt || inc == '0) begin
         return cur;
      end else if (neg) begin
         return (sum[18] || sum[17:0] <= tgt) ? tgt : sum[17:0];
      end else begin
         return (sum[18] || sum[17:0] >= tgt) ? tgt : sum[17:0];
      end
   endfunction : step_env

   function automatic logic due(input logic [1:0] exp_bits,
                                input logic [6:0] cnt);
      logic [6:0] mask;
      unique case (exp_bits)                                  // [R4]
         2'h0: mask = `SCP_RATE_MASK_128;
         2'h1: mask = `SCP_RATE_MASK_32;
         2'h2: mask = `SCP_RATE_MASK_8;
         2'h3: mask = `SCP_RATE_MASK_2;
      endcase
      return (cnt & mask) == 7'h00;
   endfunction : due

   ////////////////////////////////////////////////////////////////////////////

   assign sel_addr = r_q.options[`SCP_OPT_ALE] ? r_q.ale_addr
                                               : addr_s;     // [R15]
   assign wr_trail = r_q.wr_act && !(!cs_s && !wr_s);        // [R21]
   assign done     = (r_q.state == scp_pkg::st_exec) &&
                     (r_q.cnt == '0);
   assign harm_lim = r_q.options[`SCP_OPT_H40] ? `SCP_HARMS_SMALL
                                               : `SCP_HARMS_FULL;

   always_comb begin
      r_d = r_q;
      r_d.aux_stb = 1'b0;

      // Bus capture: data is sampled all through the strobe and the last
      // sample is used, since the trailing edge is seen a cycle late.
      r_d.wr_act = !cs_s && !wr_s;
      if (r_d.wr_act) begin
         r_d.wr_data = data_s;
         r_d.wr_addr = sel_addr;
      end
      if (ale_s) begin
         r_d.ale_addr = data_s[1:0];
      end
      r_d.data_oe = !cs_s && !rd_s;
      unique case (sel_addr)                                  // [R22]
         `SCP_ADDR_CMD: r_d.data_out = r_q.cmd;
         `SCP_ADDR_A:   r_d.data_out = r_q.buf_a;
         `SCP_ADDR_B:   r_d.data_out = r_q.buf_b;
         `SCP_ADDR_C:   r_d.data_out = r_q.buf_c;
      endcase

      if (wr_trail) begin
         unique case (r_q.wr_addr)                            // [R22]
            `SCP_ADDR_CMD: begin
               // A command during execution is dropped; the host waits.
               if (r_q.state == scp_pkg::st_idle) begin       // [R26]
                  r_d.cmd   = r_q.wr_data;                    // [R21]
                  r_d.state = scp_pkg::st_exec;
                  r_d.cnt   = `SCP_CNT_W'(EXEC_CYCLES - 1);
               end
            end
            `SCP_ADDR_A: r_d.buf_a = r_q.wr_data;
            `SCP_ADDR_B: r_d.buf_b = r_q.wr_data;
            `SCP_ADDR_C: r_d.buf_c = r_q.wr_data;
         endcase
      end

      if (r_q.state == scp_pkg::st_exec && r_q.cnt != '0) begin
         r_d.cnt = r_q.cnt - `SCP_CNT_W'(1);
      end

      // Envelopes only move while the sequencer runs.
      if (sample_tick && r_q.control[`SCP_CTL_RUN]) begin     // [R17]
         r_d.sub_cnt = r_q.sub_cnt + 7'h01;
         for (int v = 0; v < `SCP_VOICES; v++) begin
            if (due(r_q.v_slope[v][`SCP_EXP_HI:`SCP_EXP_LO],
                    r_q.sub_cnt)) begin                       // [R4]
               r_d.v_cur[v] = step_env(r_q.v_cur[v], r_q.v_slope[v],
                                {r_q.v_dest[v],
                                 `SCP_FRAC_W'(0)});           // [R5]
            end
         end
         for (int h = 0; h < `SCP_HARMS; h++) begin
            if (7'(h) < harm_lim &&
                due(r_q.h_slope[h][`SCP_EXP_HI:`SCP_EXP_LO],
                    r_q.sub_cnt)) begin                       // [R13]
               r_d.h_cur[h] = `SCP_ACUR_W'(step_env(
                                {5'h00, r_q.h_cur[h]}, r_q.h_slope[h],
                                {5'h00, r_q.h_dest[h],
                                 `SCP_FRAC_W'(0)}));          // [R9]
            end
         end
      end

      // Completion: a command write wins over envelope stepping.
      if (done) begin
         r_d.state = scp_pkg::st_idle;
         if (r_q.cmd[7:3] == `SCP_OP_PBP) begin               // [R1] [R19]
            r_d.v_slope[r_q.cmd[2:0]] = r_q.buf_a;            // [R25]
            r_d.v_dest[r_q.cmd[2:0]]  = {r_q.buf_b[4:0],
                                         r_q.buf_c};          // [R25]
            if (r_q.buf_a == 8'h00) begin                     // [R2]
               r_d.v_cur[r_q.cmd[2:0]] = {r_q.buf_b[4:0], r_q.buf_c,
                                          `SCP_FRAC_W'(0)};
            end
         end else if (r_q.cmd[7:3] == `SCP_OP_RDP) begin      // [R10]
            r_d.buf_b = {3'h0, r_q.v_cur[r_q.cmd[2:0]][17:13]};
            r_d.buf_c = r_q.v_cur[r_q.cmd[2:0]][12:5];
         end else if (r_q.cmd[7:4] == `SCP_OP_OPT) begin      // [R12]
            r_d.options = r_q.cmd[3:0];
         end else if (r_q.cmd[7:4] == `SCP_OP_CTL) begin      // [R16]
            r_d.control = r_q.cmd[1:0];
         end else if (r_q.cmd[7:6] == `SCP_OP_HBP) begin      // [R6]
            r_d.h_slope[r_q.cmd[5:0]] = r_q.buf_a;
            r_d.h_dest[r_q.cmd[5:0]]  = r_q.buf_c;
            if (r_q.buf_a == 8'h00) begin                     // [R7]
               r_d.h_cur[r_q.cmd[5:0]] = {r_q.buf_c,
                                          `SCP_FRAC_W'(0)};
            end
         end else if (r_q.cmd[7:6] == `SCP_OP_RDA) begin      // [R11]
            r_d.buf_c = r_q.h_cur[r_q.cmd[5:0]][12:5];
            r_d.buf_b = {3'h0, r_q.h_cur[r_q.cmd[5:0]][4:0]};
         end else if (r_q.cmd[7:6] == `SCP_OP_AUX) begin      // [R18]
            r_d.aux_stb = 1'b1;
         end
      end

      // Ready level follows the busy state; interrupt is one clock wide.
      if (r_q.options[`SCP_OPT_INT]) begin                    // [R23]
         r_d.status = done;
      end else begin
         r_d.status = (r_d.state == scp_pkg::st_idle);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r_q         <= '0;
         r_q.options <= `SCP_OPT_RST;                         // [R24]
         r_q.control <= `SCP_CTL_RST;                         // [R24]
         r_q.status  <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   assign db_out            = r_q.data_out;
   assign db_oe             = r_q.data_oe;
   assign rdy_int           = r_q.status;
   assign ale_mode          = r_q.options[`SCP_OPT_ALE];      // [R13]
   assign int_mode          = r_q.options[`SCP_OPT_INT];
   assign individual_mode   = r_q.options[`SCP_OPT_INDIV];
   assign harm40_mode       = r_q.options[`SCP_OPT_H40];
   assign sequencer_run_bit = r_q.control[`SCP_CTL_RUN];
   assign noise_init_bit    = r_q.control[`SCP_CTL_NOISE];
   assign samp_hold_zero    = !r_q.control[`SCP_CTL_RUN];     // [R17]
   assign aux_cmd_stb       = r_q.aux_stb;
   assign aux_cmd           = r_q.cmd;
   assign aux_is_noise      = r_q.control[`SCP_CTL_NOISE];    // [R18]

   ////////////////////////////////////////////////////////////////////////////

   a_reset_clear: assert property (@(posedge core_clk)
      !rst_n |=> (r_q.options == 4'h0 && r_q.control == 2'h0)) // [R24]
      else $error("options or control not cleared by reset");

   a_cmd_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
      (wr_trail && r_q.wr_addr == `SCP_ADDR_CMD &&
       r_q.state == scp_pkg::st_idle)
      |=> (r_q.cmd == $past(r_q.wr_data) &&
           r_q.state == scp_pkg::st_exec))                    // [R21]
      else $error("command byte not latched at strobe end");

   a_cmd_done: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(r_q.state == scp_pkg::st_exec)
      |-> ##[1:EXEC_MAX] done)                                // [R23]
      else $error("command did not complete in time");

   a_ready_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!r_q.options[`SCP_OPT_INT] && r_q.state == scp_pkg::st_exec)
      |-> !rdy_int)                                           // [R23]
      else $error("ready high while a command executes");

   a_int_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r_q.options[`SCP_OPT_INT] && $past(r_q.options[`SCP_OPT_INT]) &&
       done) |=> rdy_int ##1 (!rdy_int ||
                 !r_q.options[`SCP_OPT_INT]))                 // [R23]
      else $error("interrupt pulse not one clock wide");

   a_opts_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      (done && r_q.cmd[7:4] == `SCP_OP_OPT)
      |=> (r_q.options == $past(r_q.cmd[3:0]) &&
           $stable(r_q.buf_a) && $stable(r_q.buf_c)))         // [R12]
      else $error("options not loaded from command byte");

   a_ctrl_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      (done && r_q.cmd[7:4] == `SCP_OP_CTL)
      |=> (r_q.control == $past(r_q.cmd[1:0]) &&
           samp_hold_zero == !r_q.control[0]))                // [R16]
      else $error("control not loaded from command byte");

   a_pitch_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      (done && r_q.cmd[7:3] == `SCP_OP_PBP && r_q.buf_a == 8'h00)
      |=> (r_q.v_cur[$past(r_q.cmd[2:0])][17:5] ==
           {$past(r_q.buf_b[4:0]), $past(r_q.buf_c)}))        // [R2]
      else $error("zero slope pitch not loaded immediate");

   a_harm_bp: assert property (@(posedge core_clk) disable iff (!rst_n)
      (done && r_q.cmd[7:6] == `SCP_OP_HBP)
      |=> (r_q.h_slope[$past(r_q.cmd[5:0])] == $past(r_q.buf_a) &&
           r_q.h_dest[$past(r_q.cmd[5:0])] == $past(r_q.buf_c)))  // [R6]
      else $error("harmonic breakpoint not stored");

   a_read_pitch: assert property (@(posedge core_clk) disable iff (!rst_n)
      (done && r_q.cmd[7:3] == `SCP_OP_RDP)
      |=> (r_q.buf_c == $past(r_q.v_cur[r_q.cmd[2:0]][12:5]) &&
           $stable(r_q.buf_a)))                               // [R10]
      else $error("current pitch not placed in buffers");

   a_bus_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!cs_s && !rd_s) |=> db_oe)                             // [R22]
      else $error("data bus not driven on read");

endmodule : scp_cmd_port

/* hw/scp_map.svh */
// Register addresses, opcodes, field positions, reset values and timing counts
// for the synthesizer command port.
// Assumes it is included by the package and by the design modules.
//
// What this block does
// R1 - Pitch breakpoint write stores slope and destination.
// R2 - Zero pitch slope loads destination as current.
// R3 - Pitch increment is sign plus five-bit mantissa.
// R4 - Exponent bits pick 128, 32, 8, 2 periods.
// R5 - Pitch destination thirteen bits, linear current value.
// R6 - Harmonic breakpoint takes slope A, destination C.
// R7 - Zero harmonic slope loads destination as current.
// R8 - Harmonic increment is sign plus five-bit mantissa.
// R9 - Harmonic destination is an eight-bit code.
// R10 - Read pitch fills buffers B and C.
// R11 - Read amplitude fills buffer C, B overwritten.
// R12 - Options command loads low four bits.
// R13 - Options bits select bus, pin, output, harmonics.
// R14 - Host puts latched address on DB1-DB0.
// R15 - Address-pin mode selects from address pins.
// R16 - Control command loads low two bits.
// R17 - Control bit 0 selects halt or run.
// R18 - Control bit 1 selects noise initialise mode.
// R19 - Registers by command byte, RAM via buffers.
// R20 - Host holds reset 2 ms after power; the bench holds it for 16 clocks (320 ns).
// R21 - Command latched on trailing write strobe edge.
// R22 - Address 00 command, 01 A, 10 B, 11 C.
// R23 - Status pin shows ready level or pulse.
// R24 - Reset clears options and control registers.
// R25 - Pitch destination high from B, low C.
// R26 - Host waits for completion before next command.
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

`define SCP_ADDR_CMD        2'h0
`define SCP_ADDR_A          2'h1
`define SCP_ADDR_B          2'h2
`define SCP_ADDR_C          2'h3

`define SCP_VOICES          8
`define SCP_HARMS           64
`define SCP_HARMS_SMALL     7'h28
`define SCP_HARMS_FULL      7'h40
`define SCP_EXEC_CYCLES     4
`define SCP_CNT_W           8
`define SCP_FRAC_W          5
`define SCP_PITCH_W         13
`define SCP_PCUR_W          18
`define SCP_AMP_W           8
`define SCP_ACUR_W          13

`define SCP_OPT_RST         4'h0
`define SCP_CTL_RST         2'h0
`define SCP_OPT_ALE         0
`define SCP_OPT_INT         1
`define SCP_OPT_INDIV       2
`define SCP_OPT_H40         3
`define SCP_CTL_RUN         0
`define SCP_CTL_NOISE       1

`define SCP_SLOPE_SIGN      7
`define SCP_EXP_HI          6
`define SCP_EXP_LO          5
`define SCP_MANT_HI         4
`define SCP_RATE_MASK_128   7'h7F
`define SCP_RATE_MASK_32    7'h1F
`define SCP_RATE_MASK_8     7'h07
`define SCP_RATE_MASK_2     7'h01

`define SCP_OP_PBP          5'h01
`define SCP_OP_VTYPE        5'h02
`define SCP_OP_RDP          5'h03
`define SCP_OP_OPT          4'h2
`define SCP_OP_CTL          4'h3
`define SCP_OP_HBP          2'h1
`define SCP_OP_AUX          2'h2
`define SCP_OP_RDA          2'h3

`define SCP_SYNC_RST        14'h3800

`endif

/* hw/scp_pkg.sv */
// Types shared by the command port modules.
// Assumes the constants header sits beside it on the include path.
`include "scp_map.svh"

package scp_pkg;

   typedef enum logic {st_idle, st_exec} scp_state_t;

   typedef struct packed {
      scp_state_t                                state;
      logic [`SCP_CNT_W-1:0]                     cnt;
      logic [7:0]                                cmd;
      logic [7:0]                                buf_a;
      logic [7:0]                                buf_b;
      logic [7:0]                                buf_c;
      logic [7:0]                                wr_data;
      logic [1:0]                                wr_addr;
      logic [1:0]                                ale_addr;
      logic                                      wr_act;
      logic [3:0]                                options;
      logic [1:0]                                control;
      logic                                      status;
      logic [7:0]                                data_out;
      logic                                      data_oe;
      logic                                      aux_stb;
      logic [6:0]                                sub_cnt;
      logic [`SCP_VOICES-1:0][7:0]               v_slope;
      logic [`SCP_VOICES-1:0][`SCP_PITCH_W-1:0]  v_dest;
      logic [`SCP_VOICES-1:0][`SCP_PCUR_W-1:0]   v_cur;
      logic [`SCP_HARMS-1:0][7:0]                h_slope;
      logic [`SCP_HARMS-1:0][`SCP_AMP_W-1:0]     h_dest;
      logic [`SCP_HARMS-1:0][`SCP_ACUR_W-1:0]    h_cur;
   } scp_regs_t;

endpackage : scp_pkg

/* hw/scp_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to core_clk; each bit is treated alone.
`timescale 1ns/1ns

module scp_sync #(
   parameter int unsigned     W       = 1,
   parameter logic [W-1:0]    RST_VAL = '0
) (
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   input  wire logic [W-1:0]  pin_in,
   output logic      [W-1:0]  pin_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } scp_sync_t;

   scp_sync_t r_q;
   scp_sync_t r_d;

   always_comb begin
      r_d.s1 = pin_in;
      r_d.s2 = r_q.s1;
   end

   // Reset to the idle pin levels so no strobe appears out of reset.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r_q <= {RST_VAL, RST_VAL};
      end else begin
         r_q <= r_d;
      end
   end

   assign pin_out = r_q.s2;

endmodule : scp_sync
